// >>> verilog/sttm_consts.svh
// register offsets, field positions and timing constants of the scsi timeout timers
`ifndef STTM_CONSTS_SVH
`define STTM_CONSTS_SVH

`define STTM_CLK_MHZ 250
`define STTM_BASE_SLOW_NS 125000
`define STTM_BASE_FAST_NS 100000
`define STTM_ABORT_NS 200000
`define STTM_NS_TO_CYC(ns) (((ns) * `STTM_CLK_MHZ) / 1000)

`define STTM_IDX_MASK1 7'h41
`define STTM_IDX_STATUS 7'h43
`define STTM_IDX_TIME0 7'h48
`define STTM_IDX_TIME1 7'h49
`define STTM_IDX_CTL3 7'h53

`define STTM_BIT_HTH 0
`define STTM_BIT_GEN 1
`define STTM_BIT_STO 2
`define STTM_T1_HANDSHAKE_SCALE_BIT 4
`define STTM_T1_FREERUN_SCALE_BIT 5
`define STTM_CTL3_FIFTY 0
`define STTM_SCALE_SHIFT 4

`define STTM_RST_TIME0 8'h00
`define STTM_RST_TIME1 8'h00
`define STTM_RST_MASK1 3'h0
`define STTM_RST_CTL3 1'h0

`endif

// >>> verilog/sttm_pkg.sv
// types shared by the scsi timeout timer block
`default_nettype none
package sttm_pkg;
    typedef logic [18:0] sttm_count_t;
    typedef logic [3:0] sttm_code_t;
    typedef enum logic [3:0] {
        SEL_IDLE  = 4'h1,
        SEL_COUNT = 4'h2,
        SEL_ABORT = 4'h4,
        SEL_DONE  = 4'h8
    } sttm_sel_state_t;
endpackage
`default_nettype wire

// >>> verilog/sttm_tick_gen.sv
// base tick prescaler: one enable pulse per shortest timeout unit
`timescale 1ns/1ns
`default_nettype none
module sttm_tick_gen #(
    parameter int SLOW_CYC = 31250,
    parameter int FAST_CYC = 25000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fast_i,
    output logic tick_o
);
    import sttm_pkg::*;

    logic [15:0] div_ff;
    logic fast_ff;
    logic [15:0] top;

    assign top = fast_ff ? 16'(FAST_CYC - 1) : 16'(SLOW_CYC - 1);

    // a clock-setting change restarts the unit so no short first tick appears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff <= 16'h0000;
            fast_ff <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            fast_ff <= fast_i;
            if (fast_i != fast_ff || div_ff == top) begin
                div_ff <= 16'h0000;
            end else begin
                div_ff <= div_ff + 16'h0001;
            end
            tick_o <= (fast_i == fast_ff) && (div_ff == top);
        end
    end
endmodule
`default_nettype wire

// >>> verilog/sttm_timers.sv
// scsi timeout timers: handshake, selection and general timers with wishbone registers
// Summary of operation
// RQ1: selection or reselection without answer in time sets status bit 2.
// RQ2: general timer expiry sets status bit 1; it times enable to disable.
// RQ3: handshake timer running out sets status bit 0.
// RQ4: handshake gap is request to request as target, ack to ack as initiator.
// RQ5: config bits 7-4 choose the longest gap between handshakes.
// RQ6: handshake gap exceeded raises interrupt and sets its status flag.
// RQ7: one 4-bit code, zero off, doubling from 125 us to 2.048 s.
// RQ8: fifty megahertz setting scales codes from 100 us to 1.6384 s.
// RQ9: config bits 3-0 set selection timeout; flag waits extra 200 us.
// RQ10: reading the status register clears the conditions it reports; the code clears status as at the ack edge, a cycle after sampling.
// RQ11: clearing a mask bit masks the interrupt; status still records.
// RQ12: scale bits in second timer register lengthen their timer sixteenfold.
// RQ13: software writes period zero first to restart or change a timer.
// RQ14: timers count prescaled ticks; handshake timer restarts per edge, runs in transfer.
// RQ15: period code zero never expires and holds its count at zero.
`timescale 1ns/1ns
`default_nettype none
`include "sttm_consts.svh"
module sttm_timers #(
    parameter int SLOW_CYC = `STTM_NS_TO_CYC(`STTM_BASE_SLOW_NS),
    parameter int FAST_CYC = `STTM_NS_TO_CYC(`STTM_BASE_FAST_NS),
    parameter int ABORT_CYC = `STTM_NS_TO_CYC(`STTM_ABORT_NS)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic target_request_line_n_i,
    input wire logic initiator_ack_line_n_i,
    input wire logic target_mode_i,
    input wire logic xfer_active_i,
    input wire logic sel_active_i,
    output logic irq_o
);
    import sttm_pkg::*;

    function automatic sttm_count_t sttm_limit(input sttm_code_t code, input logic scale);
        sttm_count_t lim;
        lim = sttm_count_t'(1) << (code - 4'h1);
        if (scale) begin
            lim = lim << `STTM_SCALE_SHIFT;
        end
        return lim;
    endfunction

    logic [7:0] time0_ff;
    logic [7:0] time1_ff;
    logic [2:0] mask_ff;
    logic [2:0] status_ff;
    logic fifty_ff;
    logic tick;
    logic req_s1_ff, req_s2_ff, req_s3_ff;
    logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
    sttm_count_t hs_cnt_ff, gen_cnt_ff, sel_cnt_ff;
    logic [15:0] abort_cnt_ff;
    sttm_sel_state_t sel_state_ff, nxt_sel_state;
    logic acc, wr, rd;
    sttm_code_t hs_code, sel_code, gen_code;
    sttm_count_t hs_lim, sel_lim, gen_lim;
    logic hs_edge, hs_run, hs_expire, gen_expire, sel_expire;
    logic [2:0] set_ev, clr_ev;

    // RQ14 prescaled ticks
    sttm_tick_gen #(
        .SLOW_CYC(SLOW_CYC),
        .FAST_CYC(FAST_CYC)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fast_i(fifty_ff),
        .tick_o(tick)
    );

    // access lands on the edge that samples ack, matching the master's view
    assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
    assign wr = acc && wb_we_i && wb_sel_i[0];
    assign rd = acc && !wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            unique case (wb_adr_i)
                `STTM_IDX_MASK1: wb_dat_o <= {29'h0, mask_ff};
                `STTM_IDX_STATUS: wb_dat_o <= {29'h0, status_ff};
                `STTM_IDX_TIME0: wb_dat_o <= {24'h0, time0_ff};
                `STTM_IDX_TIME1: wb_dat_o <= {24'h0, time1_ff};
                `STTM_IDX_CTL3: wb_dat_o <= {31'h0, fifty_ff};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // RQ13 period rewrite restarts only through a zero code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            time0_ff <= `STTM_RST_TIME0;
            time1_ff <= `STTM_RST_TIME1;
            mask_ff <= `STTM_RST_MASK1;
            fifty_ff <= `STTM_RST_CTL3;
        end else if (wr) begin
            if (wb_adr_i == `STTM_IDX_TIME0) begin
                time0_ff <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `STTM_IDX_TIME1) begin
                time1_ff <= {2'b00, wb_dat_i[5:0]};
            end
            if (wb_adr_i == `STTM_IDX_MASK1) begin
                mask_ff <= wb_dat_i[2:0];
            end
            if (wb_adr_i == `STTM_IDX_CTL3) begin
                fifty_ff <= wb_dat_i[`STTM_CTL3_FIFTY];
            end
        end
    end

    // RQ5 RQ9 period fields
    assign hs_code = time0_ff[7:4];
    assign sel_code = time0_ff[3:0];
    assign gen_code = time1_ff[3:0];
    // RQ7 RQ8 RQ12 doubling table with scale
    assign hs_lim = sttm_limit(hs_code, time1_ff[`STTM_T1_HANDSHAKE_SCALE_BIT]);
    assign gen_lim = sttm_limit(gen_code, time1_ff[`STTM_T1_FREERUN_SCALE_BIT]);
    assign sel_lim = sttm_limit(sel_code, 1'b0);

    // bus lines are asynchronous; edge detect looks only past the first stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {req_s1_ff, req_s2_ff, req_s3_ff} <= 3'h7;
            {ack_s1_ff, ack_s2_ff, ack_s3_ff} <= 3'h7;
        end else begin
            {req_s1_ff, req_s2_ff, req_s3_ff} <= {target_request_line_n_i, req_s1_ff, req_s2_ff};
            {ack_s1_ff, ack_s2_ff, ack_s3_ff} <= {initiator_ack_line_n_i, ack_s1_ff, ack_s2_ff};
        end
    end

    // RQ4 counted edge by role
    assign hs_edge = target_mode_i ? (req_s3_ff && !req_s2_ff) : (ack_s3_ff && !ack_s2_ff);
    assign hs_run = xfer_active_i && (hs_code != 4'h0);
    // periods are minimums: the first tick may come at once, so one extra tick is counted
    assign hs_expire = hs_run && !hs_edge && tick && (hs_cnt_ff == hs_lim);

    // RQ14 restart per edge, run only in transfer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hs_cnt_ff <= 19'h0;
        end else if (!hs_run || hs_edge) begin
            hs_cnt_ff <= 19'h0;
        end else if (tick && hs_cnt_ff <= hs_lim) begin
            hs_cnt_ff <= hs_cnt_ff + 19'h1;
        end
    end

    assign gen_expire = (gen_code != 4'h0) && tick && (gen_cnt_ff == gen_lim);

    // RQ15 zero code holds count at zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_cnt_ff <= 19'h0;
        end else if (gen_code == 4'h0) begin
            gen_cnt_ff <= 19'h0;
        end else if (tick && gen_cnt_ff <= gen_lim) begin
            gen_cnt_ff <= gen_cnt_ff + 19'h1;
        end
    end

    // RQ9 period then abort interval
    always_comb begin
        nxt_sel_state = sel_state_ff;
        unique case (sel_state_ff)
            SEL_IDLE: begin
                if (sel_active_i && sel_code != 4'h0) begin
                    nxt_sel_state = SEL_COUNT;
                end
            end
            SEL_COUNT: begin
                if (!sel_active_i || sel_code == 4'h0) begin
                    nxt_sel_state = SEL_IDLE;
                end else if (tick && sel_cnt_ff == sel_lim) begin
                    nxt_sel_state = SEL_ABORT;
                end
            end
            SEL_ABORT: begin
                if (!sel_active_i || sel_code == 4'h0) begin
                    nxt_sel_state = SEL_IDLE;
                end else if (abort_cnt_ff == 16'(ABORT_CYC - 1)) begin
                    nxt_sel_state = SEL_DONE;
                end
            end
            SEL_DONE: begin
                if (!sel_active_i) begin
                    nxt_sel_state = SEL_IDLE;
                end
            end
            default: nxt_sel_state = SEL_IDLE;
        endcase
    end

    assign sel_expire = (sel_state_ff == SEL_ABORT) && (nxt_sel_state == SEL_DONE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_state_ff <= SEL_IDLE;
        end else begin
            sel_state_ff <= nxt_sel_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || sel_state_ff != SEL_COUNT) begin
            sel_cnt_ff <= 19'h0;
        end else if (tick) begin
            sel_cnt_ff <= sel_cnt_ff + 19'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || sel_state_ff != SEL_ABORT) begin
            abort_cnt_ff <= 16'h0000;
        end else begin
            abort_cnt_ff <= abort_cnt_ff + 16'h0001;
        end
    end

    // RQ1 RQ2 RQ3 RQ6 event bits
    assign set_ev = {sel_expire, gen_expire, hs_expire};
    // RQ10 read clears status as it stands at the ack edge, one cycle after the read data was sampled; write one also clears
    always_comb begin
        clr_ev = 3'h0;
        if (acc && wb_adr_i == `STTM_IDX_STATUS) begin
            if (rd) begin
                clr_ev = status_ff;
            end else if (wb_sel_i[0]) begin
                clr_ev = wb_dat_i[2:0];
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_ff <= 3'h0;
        end else begin
            status_ff <= (status_ff & ~clr_ev) | set_ev;
        end
    end

    // RQ11 mask gates only the interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((status_ff & ~clr_ev) | set_ev) & mask_ff);
        end
    end

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

    property p_hs_flag;
        @(posedge clk_i) disable iff (rst_i) hs_expire |=> status_ff[`STTM_BIT_HTH];
    endproperty
    a_hs_flag: assert property (p_hs_flag) else $error("handshake flag not set"); // RQ3

    property p_gen_flag;
        @(posedge clk_i) disable iff (rst_i) gen_expire |=> status_ff[`STTM_BIT_GEN];
    endproperty
    a_gen_flag: assert property (p_gen_flag) else $error("general flag not set"); // RQ2

    property p_sel_flag;
        @(posedge clk_i) disable iff (rst_i)
            $rose(status_ff[`STTM_BIT_STO]) |-> $past(sel_state_ff == SEL_ABORT && abort_cnt_ff == 16'(ABORT_CYC - 1));
    endproperty
    a_sel_flag: assert property (p_sel_flag) else $error("selection flag before abort"); // RQ9

    property p_sel_set;
        @(posedge clk_i) disable iff (rst_i) sel_expire |=> status_ff[`STTM_BIT_STO] && sel_state_ff == SEL_DONE;
    endproperty
    a_sel_set: assert property (p_sel_set) else $error("selection timeout not flagged"); // RQ1

    property p_zero_hold;
        @(posedge clk_i) disable iff (rst_i) (gen_code == 4'h0) |=> gen_cnt_ff == 19'h0 && !gen_expire;
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("disabled timer counted"); // RQ15

    property p_hs_restart;
        @(posedge clk_i) disable iff (rst_i) hs_edge |=> hs_cnt_ff == 19'h0;
    endproperty
    a_hs_restart: assert property (p_hs_restart) else $error("handshake edge did not restart"); // RQ14

    property p_rd_clear;
        @(posedge clk_i) disable iff (rst_i)
            (rd && wb_adr_i == `STTM_IDX_STATUS && set_ev == 3'h0) |=> status_ff == 3'h0;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("status read did not clear"); // RQ10

    property p_irq_mask;
        @(posedge clk_i) disable iff (rst_i) (mask_ff == 3'h0) |=> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised"); // RQ11

    property p_hs_irq;
        @(posedge clk_i) disable iff (rst_i) (hs_expire && mask_ff[`STTM_BIT_HTH]) |=> irq_o;
    endproperty
    a_hs_irq: assert property (p_hs_irq) else $error("handshake interrupt missing"); // RQ6
endmodule
`default_nettype wire

// >>> verification/sttm_scsi_peer.sv
// far-side scsi device model pulsing the request or acknowledge line
`timescale 1ns/1ns
`default_nettype none
module sttm_scsi_peer #(
    parameter int GAP = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic use_req_i,
    output logic req_n_o,
    output logic ack_n_o
);
    logic [7:0] cnt_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_ff <= 8'h00;
        end else if (cnt_ff == 8'(GAP - 1)) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    // lines are terminated, so a released line reads deasserted (high)
    assign req_n_o = !(run_i && use_req_i && cnt_ff < 8'h02);
    assign ack_n_o = !(run_i && !use_req_i && cnt_ff < 8'h02);
endmodule
`default_nettype wire

// >>> verification/sttm_timers_tb.sv
// self-checking bench for the scsi timeout timers
`timescale 1ns/1ns
`default_nettype none
module sttm_timers_tb;
    localparam int SLOW = 8;
    localparam int FAST = 6;
    localparam int ABORT = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [8:2] adr = 7'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] bsel = 4'h0;
    logic [31:0] rdat;
    logic ack;
    logic irq;
    logic irq_seen;
    logic tmode = 1'b1;
    logic xfer = 1'b0;
    logic sel = 1'b0;
    logic run = 1'b0;
    logic use_req = 1'b1;
    logic req_n;
    logic ack_n;
    logic [31:0] rd;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    always #2 clk_i = ~clk_i;

    sttm_timers #(.SLOW_CYC(SLOW), .FAST_CYC(FAST), .ABORT_CYC(ABORT)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .target_request_line_n_i(req_n), .initiator_ack_line_n_i(ack_n), .target_mode_i(tmode),
        .xfer_active_i(xfer), .sel_active_i(sel), .irq_o(irq)
    );

    sttm_scsi_peer #(.GAP(12)) i_peer (
        .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .use_req_i(use_req), .req_n_o(req_n), .ack_n_o(ack_n)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one classic cycle; answer sampled at the edge where ack is high
    task automatic wb_cycle(input logic [6:0] idx, input logic w, input logic [7:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        bsel <= be;
        adr <= idx;
        dat <= {24'h0, wd};
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            @(posedge clk_i);
            n++;
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        chk(n, 1);
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] wd);
        wb_cycle(idx, 1'b1, wd, 4'hf);
    endtask

    task automatic rdc(input logic [6:0] idx, input logic [31:0] exp);
        wb_cycle(idx, 1'b0, 8'h00, 4'hf);
        chk(rd, exp);
    endtask

    // restart a timer, then expect silence early and the flag late
    task automatic tim(input logic [6:0] idx, input logic [7:0] v, input int early, input int late,
                       input logic [31:0] exp);
        wr(idx, 8'h00);
        wr(idx, v);
        wt(early);
        rdc(7'h43, 32'h0);
        wt(late - early);
        irq_seen = irq;
        rdc(7'h43, exp);
    endtask

    initial begin
        wt(2);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(7'h48, 32'h0);
        rdc(7'h43, 32'h0);
        rdc(7'h10, 32'h0);
        wr(7'h48, 8'ha5);
        rdc(7'h48, 32'ha5);
        wr(7'h48, 8'h00);
        wr(7'h41, 8'h07);
        tim(7'h49, 8'h02, SLOW - 4, 3 * SLOW, 32'h2);
        chk(irq_seen, 32'h1);
        wt(1);
        chk(irq, 32'h0);
        rdc(7'h43, 32'h0);
        wr(7'h41, 8'h05);
        tim(7'h49, 8'h02, SLOW - 4, 3 * SLOW, 32'h2);
        chk(irq_seen, 32'h0);
        wr(7'h41, 8'h07);
        tim(7'h49, 8'h21, 15 * SLOW - 8, 16 * SLOW + 8, 32'h2);
        wr(7'h53, 8'h01);
        tim(7'h49, 8'h04, 7 * FAST - 8, 8 * FAST + 4, 32'h2);
        wr(7'h53, 8'h00);
        wr(7'h49, 8'h00);
        wr(7'h48, 8'h01);
        sel <= 1'b1;
        wt(ABORT - 4);
        rdc(7'h43, 32'h0);
        wt(SLOW + 8);
        rdc(7'h43, 32'h4);
        sel <= 1'b0;
        wt(2);
        sel <= 1'b1;
        wt(ABORT - 6);
        sel <= 1'b0;
        wt(2 * ABORT);
        rdc(7'h43, 32'h0);
        wr(7'h48, 8'h30);
        xfer <= 1'b1;
        run <= 1'b1;
        wt(10 * SLOW);
        rdc(7'h43, 32'h0);
        // only acknowledge pulses while acting as target
        use_req <= 1'b0;
        wt(5 * SLOW);
        chk(irq, 32'h1);
        rdc(7'h43, 32'h1);
        xfer <= 1'b0;
        tmode <= 1'b0;
        wt(2);
        xfer <= 1'b1;
        wt(10 * SLOW);
        rdc(7'h43, 32'h0);
        run <= 1'b0;
        xfer <= 1'b0;
        wt(10 * SLOW);
        rdc(7'h43, 32'h0);
        xfer <= 1'b1;
        wr(7'h48, 8'h00);
        wt(10 * SLOW);
        rdc(7'h43, 32'h0);
        // a write without lane 0 enabled leaves the period untouched
        wb_cycle(7'h48, 1'b1, 8'h5a, 4'h0);
        rdc(7'h48, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
